// *** hdl/jrxla_map.svh ***
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 12-bit byte address on the register port, 8-bit registers
// Notes: definitions only
`ifndef JRXLA_MAP_SVH
`define JRXLA_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define JRXLA_OFF_COARSE 12'h0B0
`define JRXLA_OFF_FINE 12'h0B1
`define JRXLA_OFF_ADJ_LO 12'h4A3
`define JRXLA_OFF_ADJ_HI 12'h4A4
`define JRXLA_OFF_SKEW 12'h4A5
`define JRXLA_OFF_SUBCLASS 12'h4AE

// ------------------------------------------------------------
// field positions and codes
// ------------------------------------------------------------
`define JRXLA_SUBCLASS_MSB 7
`define JRXLA_SUBCLASS_LSB 5
`define JRXLA_COARSE_MSB 4
`define JRXLA_SUBCLASS0 3'h0
`define JRXLA_SUBCLASS1 3'h1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define JRXLA_RST_COARSE 5'h00
`define JRXLA_RST_FINE 8'h00
`define JRXLA_RST_ADJ 16'h0000
`define JRXLA_RST_SKEW 8'h00
`define JRXLA_RST_SUBCLASS 3'h0

// ------------------------------------------------------------
// timing counts and widths
// ------------------------------------------------------------
`define JRXLA_FRAME_CYCLES 4
`define JRXLA_FRAMES_PER_MF 32
`define JRXLA_PHASE_W 16
`define JRXLA_DATA_W 64
`define JRXLA_SKEW_MAX 8'hFF

`endif

// *** hdl/jrxla_pkg.sv ***
// Purpose: shared types of the receive boundary alignment block
// Assumes: constants come from jrxla_map.svh
// Notes: state structs are registered whole by their modules
`include "jrxla_map.svh"

package jrxla_pkg;

   typedef logic [11:0] jrxla_addr_t;
   typedef logic [7:0] jrxla_byte_t;

   // ------------------------------------------------------------
   // delay counter state
   // ------------------------------------------------------------
   typedef struct packed {
      logic busy;
      logic [15:0] cnt;
   } jrxla_dly_s;

   // ------------------------------------------------------------
   // top-level state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] subclass;
      logic [4:0] coarse;
      logic [7:0] fine;
      logic [15:0] adj;
      logic [7:0] skew;
      logic [7:0] skew_cnt;
      logic skew_run;
      logic [`JRXLA_PHASE_W-1:0] phase;
      logic [7:0] rdata;
      logic [`JRXLA_DATA_W-1:0] sample;
      logic sample_valid;
   } jrxla_state_s;

endpackage : jrxla_pkg

// *** hdl/jrxla_delay_counter.sv ***
// Purpose: one-shot delay, pulses done a programmed number of cycles after start
// Assumes: start and load value are synchronous to clk
// Notes: a zero load gives done in the start cycle; a new start restarts the count
`timescale 1ns/10ps

module jrxla_delay_counter (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [15:0] load_val,
   output logic done
);
   import jrxla_pkg::*;

   jrxla_dly_s state_reg;
   jrxla_dly_s state_next;

   assign done = (start && (load_val == 16'h0000)) ||
                 (!start && state_reg.busy && (state_reg.cnt == 16'h0001));

   always_comb begin
      state_next = state_reg;
      if (start) begin
         state_next.busy = (load_val != 16'h0000);
         state_next.cnt = load_val;
      end else if (state_reg.busy) begin
         state_next.cnt = state_reg.cnt - 16'h0001;
         if (state_reg.cnt == 16'h0001) begin
            state_next.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule // jrxla_delay_counter

// *** hdl/jrxla_top.sv ***
// Purpose: deterministic-latency boundary alignment for the link receiver
// Assumes: core_clk serves as both converter clock and receiver sample clock
// Notes: registers are 8 bits at the byte offsets in jrxla_map.svh
`timescale 1ns/10ps
`include "jrxla_map.svh"

module jrxla_top #(
   parameter int FRAME_CYCLES = `JRXLA_FRAME_CYCLES,
   parameter int FRAMES_PER_MF = `JRXLA_FRAMES_PER_MF
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire jrxla_pkg::jrxla_addr_t reg_addr,
   input wire jrxla_pkg::jrxla_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output jrxla_pkg::jrxla_byte_t reg_rdata,
   input wire logic sysref,
   input wire logic lane_boundary,
   input wire logic [`JRXLA_DATA_W-1:0] frame_data,
   input wire logic frame_valid,
   output logic local_boundary,
   output logic transport_boundary,
   output logic subclass_invalid,
   output logic [`JRXLA_DATA_W-1:0] sample_data,
   output logic sample_valid
);
   import jrxla_pkg::*;

   localparam logic [`JRXLA_PHASE_W-1:0] MF_LAST = `JRXLA_PHASE_W'(FRAME_CYCLES * FRAMES_PER_MF - 1);
   localparam logic [15:0] FRAME_LEN = 16'(FRAME_CYCLES);

   jrxla_state_s state_reg;
   jrxla_state_s state_next;

   // delay chain strobes
   logic sysref_take;
   logic fine_done;
   logic coarse_done;
   logic [15:0] coarse_cycles;

   // ------------------------------------------------------------
   // sysref to local boundary
   // ------------------------------------------------------------
   // invalid code check
   assign subclass_invalid = (state_reg.subclass != `JRXLA_SUBCLASS0) &&
                             (state_reg.subclass != `JRXLA_SUBCLASS1);
   // sysref used in subclass 1 only
   assign sysref_take = sysref && (state_reg.subclass == `JRXLA_SUBCLASS1);
   assign coarse_cycles = 16'(state_reg.coarse * FRAME_LEN);

   jrxla_delay_counter u_fine (
      .core_clk(core_clk),
      .reset(reset),
      .start(sysref_take),
      .load_val({8'h00, state_reg.fine}),
      .done(fine_done)
   );

   jrxla_delay_counter u_coarse (
      .core_clk(core_clk),
      .reset(reset),
      .start(fine_done),
      .load_val(coarse_cycles),
      .done(coarse_done)
   );

   // decoded from the registered phase, so it never glitches
   assign local_boundary = (state_reg.phase == '0);

   // ------------------------------------------------------------
   // transport boundary
   // ------------------------------------------------------------
   // transport boundary delay
   // a count of one multiframe or more restarts on each local boundary and never fires
   jrxla_delay_counter u_tpl (
      .core_clk(core_clk),
      .reset(reset),
      .start(local_boundary),
      .load_val(state_reg.adj),
      .done(transport_boundary)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = state_reg.rdata;
   assign sample_data = state_reg.sample;
   assign sample_valid = state_reg.sample_valid;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.rdata = 8'h00;

      // ------------------------------------------------------------
      // multiframe phase
      // ------------------------------------------------------------
      // local multiframe phase, realigned when the sysref delay expires
      if (coarse_done) begin
         state_next.phase = '0;
      end else if (state_reg.phase == MF_LAST) begin
         state_next.phase = '0;
      end else begin
         state_next.phase = state_reg.phase + 1'b1;
      end

      // ------------------------------------------------------------
      // boundary offset
      // ------------------------------------------------------------
      // offset measurement
      // saturates at JRXLA_SKEW_MAX so a late lane boundary reads as full scale, not a wrapped value
      if (local_boundary) begin
         state_next.skew_cnt = 8'h01;
         state_next.skew_run = 1'b1;
      end else if (state_reg.skew_run && state_reg.skew_cnt != `JRXLA_SKEW_MAX) begin
         state_next.skew_cnt = state_reg.skew_cnt + 8'h01;
      end
      if (lane_boundary) begin
         state_next.skew = local_boundary ? 8'h00 : state_reg.skew_cnt;
         state_next.skew_run = 1'b0;
      end

      // ------------------------------------------------------------
      // sample path
      // ------------------------------------------------------------
      // frame to sample transfer
      state_next.sample_valid = frame_valid;
      if (frame_valid) begin
         state_next.sample = frame_data;
      end

      // ------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------
      // a write to the read-only offset falls to default and is dropped
      if (reg_wr) begin
         case (reg_addr)
            `JRXLA_OFF_SUBCLASS: begin
               state_next.subclass = reg_wdata[`JRXLA_SUBCLASS_MSB:`JRXLA_SUBCLASS_LSB];
            end
            `JRXLA_OFF_COARSE: begin
               state_next.coarse = reg_wdata[`JRXLA_COARSE_MSB:0];
            end
            `JRXLA_OFF_FINE: begin
               state_next.fine = reg_wdata;
            end
            `JRXLA_OFF_ADJ_LO: begin
               state_next.adj[7:0] = reg_wdata;
            end
            `JRXLA_OFF_ADJ_HI: begin
               state_next.adj[15:8] = reg_wdata;
            end
            default: begin
               state_next.adj = state_reg.adj;
            end
         endcase
      end

      // ------------------------------------------------------------
      // register reads
      // ------------------------------------------------------------
      // only the cycle after a read carries data; every other cycle reads zero
      if (reg_rd) begin
         case (reg_addr)
            `JRXLA_OFF_SUBCLASS: begin
               state_next.rdata = {state_reg.subclass, 5'h00};
            end
            `JRXLA_OFF_COARSE: begin
               state_next.rdata = {3'h0, state_reg.coarse};
            end
            `JRXLA_OFF_FINE: begin
               state_next.rdata = state_reg.fine;
            end
            `JRXLA_OFF_ADJ_LO: begin
               state_next.rdata = state_reg.adj[7:0];
            end
            `JRXLA_OFF_ADJ_HI: begin
               state_next.rdata = state_reg.adj[15:8];
            end
            `JRXLA_OFF_SKEW: begin
               state_next.rdata = state_reg.skew;
            end
            default: begin
               state_next.rdata = 8'h00;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         // phase restarts at zero, so a boundary pulse follows reset
         state_reg <= '0;
         state_reg.subclass <= `JRXLA_RST_SUBCLASS;
         state_reg.coarse <= `JRXLA_RST_COARSE;
         state_reg.fine <= `JRXLA_RST_FINE;
         state_reg.adj <= `JRXLA_RST_ADJ;
         state_reg.skew <= `JRXLA_RST_SKEW;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule // jrxla_top

// *** sim/jrxla_sva.sv ***
// Purpose: port assertions for jrxla_top
// Assumes: fields change only by register writes
// Notes: shadow fields qualify the antecedents
`timescale 1ns/10ps
`include "jrxla_map.svh"
module jrxla_sva (
   input wire logic core_clk,
   input wire logic reset,
   input wire jrxla_pkg::jrxla_addr_t reg_addr,
   input wire jrxla_pkg::jrxla_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic sysref,
   input wire logic local_boundary,
   input wire logic transport_boundary,
   input wire logic subclass_invalid,
   input wire logic frame_valid,
   input wire logic sample_valid
);
   import jrxla_pkg::*;
   logic [2:0] sub_q;
   logic [12:0] dly_q;
   logic [15:0] adj_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         {sub_q, dly_q, adj_q} <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            `JRXLA_OFF_SUBCLASS: sub_q <= reg_wdata[7:5];
            `JRXLA_OFF_COARSE: dly_q[12:8] <= reg_wdata[4:0];
            `JRXLA_OFF_FINE: dly_q[7:0] <= reg_wdata;
            `JRXLA_OFF_ADJ_LO: adj_q[7:0] <= reg_wdata;
            `JRXLA_OFF_ADJ_HI: adj_q[15:8] <= reg_wdata;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // sysref taken in subclass 1 with {coarse, fine} of zero, or of two converter clocks
   sequence s_sync0; sysref && sub_q == 3'h1 && dly_q == 13'h0000; endsequence
   sequence s_sync2; sysref && sub_q == 3'h1 && dly_q == 13'h0002; endsequence
   property p_flag; reg_wr && reg_addr == `JRXLA_OFF_SUBCLASS |=> subclass_invalid == (sub_q > 3'h1); endproperty
   a_flag: assert property (p_flag) else $error("subclass flag wrong");
   property p_n0; s_sync0 |=> local_boundary; endproperty
   a_n0: assert property (p_n0) else $error("no boundary after sysref");
   property p_lb; local_boundary |=> !local_boundary; endproperty
   a_lb: assert property (p_lb) else $error("boundary pulse too long");
   property p_n2; s_sync2 |-> ##3 local_boundary; endproperty
   a_n2: assert property (p_n2) else $error("fine delay wrong");
   property p_t0; local_boundary && adj_q == 16'h0000 |-> transport_boundary; endproperty
   a_t0: assert property (p_t0) else $error("transport pulse late");
   property p_t3; local_boundary && adj_q == 16'h0003 |-> ##3 transport_boundary; endproperty
   a_t3: assert property (p_t3) else $error("transport delay wrong");
   property p_smp; frame_valid |=> sample_valid; endproperty
   a_smp: assert property (p_smp) else $error("sample not passed on");
endmodule // jrxla_sva
bind jrxla_top jrxla_sva i_jrxla_sva (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sysref(sysref), .local_boundary(local_boundary),
   .transport_boundary(transport_boundary), .subclass_invalid(subclass_invalid),
   .frame_valid(frame_valid), .sample_valid(sample_valid));

// *** sim/jrxla_tx_model.sv ***
// Purpose: transmitter stand-in feeding lane data
// Assumes: lag between 1 and 254 cycles
// Notes: data changes every cycle so a stale copy shows
`timescale 1ns/10ps
`include "jrxla_map.svh"
module jrxla_tx_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic local_boundary,
   input wire logic [7:0] lag,
   output logic lane_boundary,
   output logic [`JRXLA_DATA_W-1:0] frame_data,
   output logic frame_valid
);
   logic [7:0] cnt;
   // lane data boundary trails the local one by lag cycles
   assign lane_boundary = cnt == lag;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt <= 8'hFF;
         frame_data <= '0;
         frame_valid <= 1'b0;
      end else begin
         cnt <= local_boundary ? 8'h01 : cnt + 8'(cnt != 8'hFF);
         frame_data <= {frame_data[`JRXLA_DATA_W-2:0], ~frame_data[`JRXLA_DATA_W-1]};
         frame_valid <= ~frame_valid;
      end
   end
endmodule // jrxla_tx_model

// *** sim/tb_jrxla_top.sv ***
// Purpose: self-checking bench for jrxla_top
// Assumes: core_clk at 250 MHz
// Notes: boundary timing counted in whole cycles
`timescale 1ns/10ps
module tb_jrxla_top;
   import jrxla_pkg::*;
   localparam int FC = 4;
   localparam int FPM = 32;
   logic core_clk, reset, reg_wr, reg_rd, sysref, lane_boundary, frame_valid;
   logic local_boundary, transport_boundary, subclass_invalid, sample_valid;
   jrxla_addr_t reg_addr = 12'h000;
   jrxla_byte_t reg_wdata = 8'h00;
   jrxla_byte_t reg_rdata;
   logic [63:0] frame_data;
   logic [63:0] sample_data;
   logic [63:0] fd;
   logic fv;
   logic [7:0] lag = 8'hC8;
   int n_errors = 0;
   int tests_run = 0;
   int c;
   jrxla_addr_t offs[7] = '{12'h0B0, 12'h0B1, 12'h4A3, 12'h4A4, 12'h4A5, 12'h4AE, 12'h123};
   int st[6][3] = '{'{32, 0, 0}, '{32, 2, 0}, '{32, 0, 1}, '{32, 2, 1}, '{64, 2, 1}, '{0, 2, 1}};
   logic [15:0] ad[4] = '{16'h0003, 16'h007F, 16'h0000, 16'h0100};
   jrxla_top #(.FRAME_CYCLES(FC), .FRAMES_PER_MF(FPM)) i_jrxla_top (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sysref(sysref), .lane_boundary(lane_boundary), .frame_data(frame_data), .frame_valid(frame_valid),
      .local_boundary(local_boundary), .transport_boundary(transport_boundary),
      .subclass_invalid(subclass_invalid), .sample_data(sample_data), .sample_valid(sample_valid));
   jrxla_tx_model i_jrxla_tx_model (.core_clk(core_clk), .reset(reset), .local_boundary(local_boundary),
      .lag(lag), .lane_boundary(lane_boundary), .frame_data(frame_data), .frame_valid(frame_valid));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input jrxla_addr_t a, input jrxla_byte_t d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input jrxla_addr_t a, input jrxla_byte_t exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   // cycles until the chosen pulse, seen at the falling edge where it is settled; a miss ends the run
   task automatic wait_for(input bit tpt);
      c = 0;
      do begin
         @(negedge core_clk);
         c++;
      end while ((tpt ? transport_boundary : local_boundary) !== 1'b1 && c < 300);
      if ((tpt ? transport_boundary : local_boundary) !== 1'b1) begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      {reset, reg_wr, reg_rd, sysref} = 4'h8;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      foreach (offs[i]) rd(offs[i], 8'h00);
      wr(12'h0B0, 8'hFF);
      rd(12'h0B0, 8'h1F);
      wr(12'h0B1, 8'hA5);
      rd(12'h0B1, 8'hA5);
      wr(12'h4A4, 8'hC3);
      rd(12'h4A4, 8'hC3);
      wr(12'h4A3, 8'h3C);
      rd(12'h4A3, 8'h3C);
      wr(12'h4A5, 8'h55);
      rd(12'h4A5, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(12'h4AE, 8'(i * 32 + 31));
         rd(12'h4AE, 8'(i * 32));
         check(subclass_invalid, 16'(i > 1));
      end
      // sysref right after a boundary, so the free-running one is far away
      foreach (st[i]) begin
         wr(12'h4AE, 8'(st[i][0]));
         wr(12'h0B1, 8'(st[i][1]));
         wr(12'h0B0, 8'(st[i][2]));
         wait_for(1'b0);
         @(posedge core_clk);
         sysref <= 1'b1;
         @(posedge core_clk);
         sysref <= 1'b0;
         wait_for(1'b0);
         check(16'(c), 16'(st[i][0] == 32 ? st[i][1] + st[i][2] * FC + 1 : FC * FPM - 1));
      end
      foreach (ad[i]) begin
         wr(12'h4A3, ad[i][7:0]);
         wr(12'h4A4, ad[i][15:8]);
         wait_for(1'b0);
         if (ad[i] < 16'(FC * FPM)) begin
            wait_for(1'b1);
            check(16'(c), ad[i] == 16'h0000 ? 16'(FC * FPM) : ad[i]);
         end else begin
            // a count beyond one multiframe is restarted before it expires
            c = 0;
            repeat (300) begin
               @(negedge core_clk);
               c += int'(transport_boundary === 1'b1);
            end
            check(16'(c), 16'h0000);
         end
      end
      // lane lag stays inside one multiframe so every local boundary sees one lane boundary
      for (int i = 5; i < FC * FPM; i += 61) begin
         lag <= 8'(i);
         wait_for(1'b0);
         wait_for(1'b0);
         rd(12'h4A5, 8'(i));
      end
      // samples follow frames by one cycle and hold while no frame is valid
      @(negedge core_clk);
      fd = frame_data;
      fv = frame_valid;
      repeat (4) begin
         @(negedge core_clk);
         check(sample_valid, fv);
         if (fv === 1'b1) check(sample_data, fd);
         fd = frame_data;
         fv = frame_valid;
      end
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end
endmodule // tb_jrxla_top
